// [logic/svss_defs.svh]
// Constants for the serial VID slave and start-up sequencer.
// Assumes a 100 MHz system clock; included by the package and the main module.
`ifndef SVSS_DEFS_SVH
`define SVSS_DEFS_SVH

// Timing
`define SVSS_CLK_PERIOD_NS   10
`define SVSS_SS_STEP_NS      1000
`define SVSS_SS_STEP_CYC     (`SVSS_SS_STEP_NS / `SVSS_CLK_PERIOD_NS)
`define SVSS_SS_STEP_RESET   16'(`SVSS_SS_STEP_CYC)

// Register byte offsets, compared against haddr[11:0]
`define SVSS_OFF_CTRL        12'h000
`define SVSS_OFF_STATUS      12'h004
`define SVSS_OFF_LAST        12'h008
`define SVSS_HSIZE_WORD      3'h2

// Status field positions
`define SVSS_ST_GOOD         0
`define SVSS_ST_SERIAL       1
`define SVSS_ST_FIXED        2
`define SVSS_ST_PARALLEL     3
`define SVSS_ST_BOOT_LO      4
`define SVSS_ST_HINT         6
`define SVSS_ST_POK          7
`define SVSS_ST_CORE_ON      8
`define SVSS_ST_AUX_ON       9
`define SVSS_ST_CORE_LO      16
`define SVSS_ST_AUX_LO       24

// Last-frame field positions
`define SVSS_LF_ADDR_LO      8
`define SVSS_LF_DISCARD      16

// Frame layout and voltage codes
`define SVSS_ADDR_FIXED      3'h6
`define SVSS_VID_OFF         7'h7c
`define SVSS_VID_RAMP_START  7'h7b
`define SVSS_BOOT_VID_0      7'h24
`define SVSS_BOOT_VID_1      7'h2c
`define SVSS_BOOT_VID_2      7'h34
`define SVSS_BOOT_VID_3      7'h3c
`define SVSS_FIX_VID_0       7'h0c
`define SVSS_FIX_VID_1       7'h1c
`define SVSS_FIX_VID_2       7'h2c
`define SVSS_FIX_VID_3       7'h3c

`endif

// [logic/svss_pkg.sv]
// Types and shared arithmetic for the serial VID slave and start-up sequencer.
// Assumes svss_defs.svh is on the include path.
`include "svss_defs.svh"
package svss_pkg;

  typedef enum logic [5:0] {
    SVSS_ST_IDLE     = 6'h01,
    SVSS_ST_SOFT     = 6'h02,
    SVSS_ST_WAIT     = 6'h04,
    SVSS_ST_RUN      = 6'h08,
    SVSS_ST_FIX      = 6'h10,
    SVSS_ST_PARALLEL = 6'h20
  } svss_state_t;

  typedef enum logic [5:0] {
    SVSS_RX_IDLE  = 6'h01,
    SVSS_RX_ADDR  = 6'h02,
    SVSS_RX_ACK_A = 6'h04,
    SVSS_RX_DATA  = 6'h08,
    SVSS_RX_ACK_D = 6'h10,
    SVSS_RX_DONE  = 6'h20
  } svss_rx_t;

  // Two-bit strap code to a VID code, boot table or fixed table
  function automatic logic [6:0] svss_boot_vid(input logic [1:0] code, input logic fixed);
    logic [6:0] v;
    v = 7'h00;
    unique case (code)
      2'h0: v = fixed ? `SVSS_FIX_VID_0 : `SVSS_BOOT_VID_0;
      2'h1: v = fixed ? `SVSS_FIX_VID_1 : `SVSS_BOOT_VID_1;
      2'h2: v = fixed ? `SVSS_FIX_VID_2 : `SVSS_BOOT_VID_2;
      2'h3: v = fixed ? `SVSS_FIX_VID_3 : `SVSS_BOOT_VID_3;
    endcase
    return v;
  endfunction

  // One code step toward the target; lower code means higher voltage
  function automatic logic [6:0] svss_step(input logic [6:0] cur, input logic [6:0] tgt);
    logic [6:0] v;
    v = cur;
    if (cur > tgt) v = 7'(cur - 7'h01);
    else if (cur < tgt) v = 7'(cur + 7'h01);
    return v;
  endfunction

endpackage

// [logic/svss_startup.sv]
// Serial VID slave and two-rail start-up sequencer with an AHB-Lite register slave.
// Assumes the six sequencer and serial VID pins are asynchronous to clk and the bus master is the only one on the wires.
// Operation
// (R1) Processor masters clock and data, fast-mode signalling
// (R2) Enable rise samples CPU type, low means serial
// (R3) Serial mode latches clock/data as boot code
// (R4) Soft-start both rails to boot level
// (R5) Boot and fixed tables decode two-bit code
// (R6) Power-ok drop returns rails to boot code
// (R7) Rails in regulation raise rails-good, await power-ok
// (R8) Without power-ok, commands are discarded
// (R9) With power-ok, valid commands execute
// (R10) Power-ok drop lowers rails-good until window
// (R11) Master sends start, address, write, byte, stop
// (R12) Acknowledge after address byte and data byte
// (R13) Command applied only after stop
// (R14) Address bits 6:4 must be 110
// (R15) Address bits 1/0 pick core/auxiliary rail
// (R16) Data bit 7 is low-power hint, active low
// (R17) Bits 6:0 voltage code, top codes mean off
// (R18) Single rail on/off keeps rails-good high
// (R19) Fixed mode follows pins, ignores power-ok
// (R20) Wrong address gets no acknowledge, wait start
// (R21) Start or stop mid-frame drops partial frame
`timescale 1ns/1ps
`default_nettype none
`include "svss_defs.svh"
module svss_startup (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        en,
  input  wire logic        cpu_type_select_pin,
  input  wire logic        fixed_voltage_strap,
  input  wire logic        cpu_power_ok_in,
  input  wire logic        serial_vid_clk,
  input  wire logic        serial_vid_data_in,
  output logic             serial_vid_data_out,
  output logic             serial_vid_data_oe_n,
  output logic             rails_good_out,
  output logic             low_power_hint_n,
  output logic [6:0]       core_vid_ref,
  output logic             core_rail_on,
  output logic [6:0]       aux_vid_ref,
  output logic             aux_rail_on,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp
);

  // Pin synchronisers
  logic [5:0] pins_s;

  svss_sync #(
    .WIDTH (6)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d_in  ({en, cpu_type_select_pin, fixed_voltage_strap, cpu_power_ok_in,
             serial_vid_clk, serial_vid_data_in}),
    .d_out (pins_s)
  );

  wire logic en_s     = pins_s[5];
  wire logic type_s   = pins_s[4];
  wire logic strap_s  = pins_s[3];
  wire logic pok_s    = pins_s[2];
  wire logic scl_s    = pins_s[1];
  wire logic sda_s    = pins_s[0];

  logic en_d;
  logic scl_d;
  logic sda_d;

  // Sequencer state
  svss_pkg::svss_state_t state;
  svss_pkg::svss_state_t next_state;
  logic        serial_mode;
  logic        fixed_mode;
  logic        parallel_mode;
  logic [1:0]  boot_code;
  logic [6:0]  core_tgt;
  logic [6:0]  aux_tgt;
  logic [6:0]  next_core_tgt;
  logic [6:0]  next_aux_tgt;
  logic        next_core_on;
  logic        next_aux_on;
  logic        next_good;
  logic        next_hint;
  logic [15:0] step_cnt;
  logic [15:0] step_period;

  // Frame receiver state
  svss_pkg::svss_rx_t rx_state;
  svss_pkg::svss_rx_t next_rx;
  logic [2:0]  bit_cnt;
  logic [2:0]  next_cnt;
  logic [7:0]  shift;
  logic [7:0]  next_shift;
  logic [6:0]  cmd_addr;
  logic [6:0]  next_addr;
  logic [7:0]  cmd_data;
  logic [7:0]  next_data;
  logic        cmd_pending;
  logic        next_pending;
  logic        next_oe_n;
  logic        discard_flag;

  // Bus slave state
  logic        wr_pend;
  logic [11:0] wr_addr;

  // Edge and condition decoding
  wire logic       en_rise    = en_s & ~en_d;
  wire logic       scl_rise   = scl_s & ~scl_d;
  wire logic       scl_fall   = ~scl_s & scl_d;
  wire logic       start_det  = scl_s & scl_d & sda_d & ~sda_s;
  wire logic       stop_det   = scl_s & scl_d & ~sda_d & sda_s;
  wire logic [7:0] shifted    = {shift[6:0], sda_s};
  wire logic       addr_ok    = (shifted[7:5] == `SVSS_ADDR_FIXED) & ~shifted[0];
  wire logic       rx_enable  = serial_mode & ~fixed_mode & (state != svss_pkg::SVSS_ST_IDLE);
  wire logic [6:0] boot_vid   = svss_pkg::svss_boot_vid(boot_code, 1'b0);
  wire logic [6:0] fix_vid    = svss_pkg::svss_boot_vid({scl_s, sda_s}, 1'b1);
  wire logic [6:0] pin_vid    = svss_pkg::svss_boot_vid({scl_s, sda_s}, strap_s);
  wire logic       at_target  = (core_vid_ref == core_tgt) & (aux_vid_ref == aux_tgt);
  wire logic       step_tick  = (step_cnt >= step_period);
  wire logic       cmd_run    = (state == svss_pkg::SVSS_ST_RUN) & pok_s;
  wire logic       cmd_apply  = stop_det & cmd_pending & cmd_run;
  wire logic       cmd_drop   = stop_det & cmd_pending & ~cmd_run;
  wire logic       cmd_off    = (cmd_data[6:0] >= `SVSS_VID_OFF);

  // Start-up sequencer
  always_comb begin
    next_state    = state;
    next_core_tgt = core_tgt;
    next_aux_tgt  = aux_tgt;
    next_core_on  = core_rail_on;
    next_aux_on   = aux_rail_on;
    next_good     = rails_good_out;
    next_hint     = low_power_hint_n;
    if (!en_s) begin
      next_state   = svss_pkg::SVSS_ST_IDLE;
      next_core_on = 1'b0;
      next_aux_on  = 1'b0;
      next_good    = 1'b0;
      next_hint    = 1'b1;
    end else begin
      unique case (state)
        svss_pkg::SVSS_ST_IDLE: begin
          if (en_rise && (strap_s || !type_s)) begin  // see (R2)
            next_state    = svss_pkg::SVSS_ST_SOFT;      // see (R4)
            next_core_tgt = pin_vid;                     // see (R5)
            next_aux_tgt  = pin_vid;
            next_core_on  = 1'b1;
            next_aux_on   = 1'b1;
          end else if (en_rise) begin
            next_state = svss_pkg::SVSS_ST_PARALLEL;
          end
        end
        svss_pkg::SVSS_ST_SOFT: begin
          if (at_target) begin
            next_good  = 1'b1;                           // see (R7) (R10)
            next_state = fixed_mode ? svss_pkg::SVSS_ST_FIX : svss_pkg::SVSS_ST_WAIT;
          end
        end
        svss_pkg::SVSS_ST_WAIT: begin
          if (pok_s) begin
            next_state = svss_pkg::SVSS_ST_RUN;          // see (R9)
          end
        end
        svss_pkg::SVSS_ST_RUN: begin
          if (!pok_s) begin
            // Back to the stored boot code with rails-good low
            next_state    = svss_pkg::SVSS_ST_SOFT;      // see (R6) (R10)
            next_good     = 1'b0;
            next_core_tgt = boot_vid;
            next_aux_tgt  = boot_vid;
            next_core_on  = 1'b1;
            next_aux_on   = 1'b1;
            next_hint     = 1'b1;
          end else if (cmd_apply) begin                  // see (R13)
            next_hint = cmd_data[7];                     // see (R16)
            if (cmd_addr[1]) begin                       // see (R15)
              next_core_on = ~cmd_off;                   // see (R17) (R18)
              if (!cmd_off) next_core_tgt = cmd_data[6:0];
            end
            if (cmd_addr[0]) begin
              next_aux_on = ~cmd_off;
              if (!cmd_off) next_aux_tgt = cmd_data[6:0];
            end
          end
        end
        svss_pkg::SVSS_ST_FIX: begin
          // Pins act as a static selector; power-ok plays no part
          next_core_tgt = fix_vid;                       // see (R19)
          next_aux_tgt  = fix_vid;
        end
        svss_pkg::SVSS_ST_PARALLEL: begin
          next_state = state;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state            <= svss_pkg::SVSS_ST_IDLE;
      core_tgt         <= `SVSS_VID_RAMP_START;
      aux_tgt          <= `SVSS_VID_RAMP_START;
      core_rail_on     <= 1'b0;
      aux_rail_on      <= 1'b0;
      rails_good_out   <= 1'b0;
      low_power_hint_n <= 1'b1;
    end else begin
      state            <= next_state;
      core_tgt         <= next_core_tgt;
      aux_tgt          <= next_aux_tgt;
      core_rail_on     <= next_core_on;
      aux_rail_on      <= next_aux_on;
      rails_good_out   <= next_good;
      low_power_hint_n <= next_hint;
    end
  end

  // Mode and boot code capture at the enable edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_mode   <= 1'b0;
      fixed_mode    <= 1'b0;
      parallel_mode <= 1'b0;
      boot_code     <= 2'h0;
    end else if (en_rise && state == svss_pkg::SVSS_ST_IDLE) begin
      serial_mode   <= strap_s | ~type_s;                // see (R2)
      fixed_mode    <= strap_s;
      parallel_mode <= ~strap_s & type_s;
      boot_code     <= {scl_s, sda_s};                   // see (R3)
    end
  end

  // Reference ramp; a rail that is off holds its last code until it is switched on again or an enable rise in idle reloads the ramp start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt     <= 16'h0000;
      core_vid_ref <= `SVSS_VID_RAMP_START;
      aux_vid_ref  <= `SVSS_VID_RAMP_START;
    end else begin
      step_cnt <= step_tick ? 16'h0000 : 16'(step_cnt + 16'h0001);
      if (en_rise && state == svss_pkg::SVSS_ST_IDLE) begin
        core_vid_ref <= `SVSS_VID_RAMP_START;
        aux_vid_ref  <= `SVSS_VID_RAMP_START;
      end else if (step_tick) begin
        if (core_rail_on) core_vid_ref <= svss_pkg::svss_step(core_vid_ref, core_tgt);  // see (R4)
        if (aux_rail_on) aux_vid_ref <= svss_pkg::svss_step(aux_vid_ref, aux_tgt);
      end
    end
  end

  // Frame receiver; the master owns the clock wire
  always_comb begin                                      // see (R1) (R11)
    next_rx      = rx_state;
    next_cnt     = bit_cnt;
    next_shift   = shift;
    next_oe_n    = serial_vid_data_oe_n;
    next_pending = cmd_pending;
    next_addr    = cmd_addr;
    next_data    = cmd_data;
    if (!rx_enable) begin
      next_rx      = svss_pkg::SVSS_RX_IDLE;
      next_oe_n    = 1'b1;
      next_pending = 1'b0;
    end else if (start_det || stop_det) begin
      // Any partial frame is dropped here
      next_rx      = start_det ? svss_pkg::SVSS_RX_ADDR : svss_pkg::SVSS_RX_IDLE;  // see (R21)
      next_cnt     = 3'h0;
      next_oe_n    = 1'b1;
      next_pending = 1'b0;
    end else begin
      unique case (rx_state)
        svss_pkg::SVSS_RX_IDLE: begin
          next_rx = rx_state;
        end
        svss_pkg::SVSS_RX_ADDR: begin
          if (scl_rise) begin
            next_shift = shifted;
            next_cnt   = 3'(bit_cnt + 3'h1);
            if (bit_cnt == 3'h7) begin
              next_addr = shifted[7:1];
              next_rx   = addr_ok ? svss_pkg::SVSS_RX_ACK_A : svss_pkg::SVSS_RX_IDLE;  // see (R14) (R20)
            end
          end
        end
        svss_pkg::SVSS_RX_ACK_A: begin
          if (scl_fall) begin
            next_oe_n = ~serial_vid_data_oe_n;           // see (R12)
            if (!serial_vid_data_oe_n) next_rx = svss_pkg::SVSS_RX_DATA;
          end
        end
        svss_pkg::SVSS_RX_DATA: begin
          if (scl_rise) begin
            next_shift = shifted;
            next_cnt   = 3'(bit_cnt + 3'h1);
            if (bit_cnt == 3'h7) begin
              next_data    = shifted;
              next_pending = 1'b1;
              next_rx      = svss_pkg::SVSS_RX_ACK_D;
            end
          end
        end
        svss_pkg::SVSS_RX_ACK_D: begin
          if (scl_fall) begin
            next_oe_n = ~serial_vid_data_oe_n;           // see (R12)
            if (!serial_vid_data_oe_n) next_rx = svss_pkg::SVSS_RX_DONE;
          end
        end
        svss_pkg::SVSS_RX_DONE: begin
          next_rx = rx_state;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_d                 <= 1'b0;
      scl_d                <= 1'b0;
      sda_d                <= 1'b0;
      rx_state             <= svss_pkg::SVSS_RX_IDLE;
      bit_cnt              <= 3'h0;
      shift                <= 8'h00;
      cmd_addr             <= 7'h00;
      cmd_data             <= 8'h00;
      cmd_pending          <= 1'b0;
      serial_vid_data_oe_n <= 1'b1;
      serial_vid_data_out  <= 1'b0;
    end else begin
      en_d                 <= en_s;
      scl_d                <= scl_s;
      sda_d                <= sda_s;
      rx_state             <= next_rx;
      bit_cnt              <= next_cnt;
      shift                <= next_shift;
      cmd_addr             <= next_addr;
      cmd_data             <= next_data;
      cmd_pending          <= next_pending;
      serial_vid_data_oe_n <= next_oe_n;
      serial_vid_data_out  <= 1'b0;
    end
  end

  // Commands finished outside the run state or while power-ok is low set the discard flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      discard_flag <= 1'b0;
    end else if (cmd_drop) begin
      discard_flag <= 1'b1;                              // see (R8)
    end else if (cmd_apply) begin
      discard_flag <= 1'b0;
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  wire logic        ahb_access = hsel & htrans[1] & hready;
  wire logic [31:0] status_word;
  wire logic [31:0] last_word;
  wire logic [31:0] rd_mux;

  assign status_word = {1'b0, aux_vid_ref, 1'b0, core_vid_ref, 6'h00, aux_rail_on, core_rail_on,
                        pok_s, low_power_hint_n, boot_code, parallel_mode, fixed_mode, serial_mode,
                        rails_good_out};
  assign last_word   = {15'h0000, discard_flag, 1'b0, cmd_addr, cmd_data};
  assign rd_mux      = (haddr[11:0] == `SVSS_OFF_CTRL)   ? {16'h0000, step_period} :
                       (haddr[11:0] == `SVSS_OFF_STATUS) ? status_word :
                       (haddr[11:0] == `SVSS_OFF_LAST)   ? last_word : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend     <= 1'b0;
      wr_addr     <= 12'h000;
      step_period <= `SVSS_SS_STEP_RESET;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      wr_pend   <= ahb_access & hwrite & (hsize == `SVSS_HSIZE_WORD);
      wr_addr   <= haddr[11:0];
      hrdata    <= (ahb_access & ~hwrite) ? rd_mux : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (wr_pend && wr_addr == `SVSS_OFF_CTRL) step_period <= hwdata[15:0];
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_mode_serial_pick: assert property (  // see (R2)
    (en_rise && state == svss_pkg::SVSS_ST_IDLE && !strap_s && !type_s) |=> (serial_mode && !parallel_mode))
    else $error("serial mode not chosen at enable edge");

  a_boot_code_latch: assert property (  // see (R3)
    (en_rise && state == svss_pkg::SVSS_ST_IDLE) |=> (boot_code == $past({scl_s, sda_s})))
    else $error("boot code not latched from pins");

  a_good_after_soft: assert property (  // see (R7)
    (state == svss_pkg::SVSS_ST_SOFT && at_target && en_s) |=> rails_good_out)
    else $error("rails-good not raised at target");

  a_pok_drop_boot: assert property (  // see (R10)
    (state == svss_pkg::SVSS_ST_RUN && !pok_s && en_s) |=> (!rails_good_out && core_tgt == boot_vid && aux_tgt == boot_vid))
    else $error("power-ok drop did not return to boot code");

  a_wait_discards: assert property (  // see (R8)
    (state == svss_pkg::SVSS_ST_WAIT && en_s) |=> ($stable(core_tgt) && $stable(aux_tgt)))
    else $error("target changed before power-ok");

  a_apply_core_cmd: assert property (  // see (R15)
    (cmd_apply && cmd_addr[1] && !cmd_off && en_s) |=> (core_tgt == $past(cmd_data[6:0]) && core_rail_on))
    else $error("core command not applied at stop");

  a_off_cmd_rail: assert property (  // see (R17)
    (cmd_apply && cmd_addr[0] && cmd_off && en_s) |=> (!aux_rail_on && rails_good_out))
    else $error("off code did not switch auxiliary rail off");

  a_ack_only_slot: assert property (  // see (R12)
    !serial_vid_data_oe_n |-> (rx_state == svss_pkg::SVSS_RX_ACK_A || rx_state == svss_pkg::SVSS_RX_ACK_D))
    else $error("data wire driven outside an acknowledge slot");

  a_addr_reject: assert property (  // see (R20)
    (rx_enable && !start_det && !stop_det && rx_state == svss_pkg::SVSS_RX_ADDR && scl_rise
     && bit_cnt == 3'h7 && !addr_ok) |=> (rx_state == svss_pkg::SVSS_RX_IDLE) [*2])
    else $error("bad address not ignored");

endmodule
`default_nettype wire

// [logic/svss_sync.sv]
// Two-flop synchroniser bank for pins from outside the clock domain.
// Assumes every bit is an independent level.
`timescale 1ns/1ps
`default_nettype none
module svss_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] d_out
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta  <= '0;
      d_out <= '0;
    end else begin
      meta  <= d_in;
      d_out <= meta;
    end
  end

endmodule
`default_nettype wire

// [tb/svss_cpu_master.sv]
// CPU-side serial VID master model: bus clock and open-drain data.
// Assumes a pull-up on the data wire; bus clock period 125 ns, idle high.
`timescale 1ns/1ps
`default_nettype none
module svss_cpu_master (
  input  wire logic dev_oe_n,
  input  wire logic dev_out,
  output var  logic vid_clk,
  output wire logic vid_data
);
  logic drv = 1'b1;
  // Wired-AND with pull-up, so a released wire reads high
  assign vid_data = drv & (dev_oe_n | dev_out);
  initial vid_clk = 1'b1;
  // Non-blocking, since the bench calls this on a clock edge
  task automatic set_lines(input logic c, input logic d);
    vid_clk <= c;
    drv <= d;
  endtask
  task automatic start_cond;
    #31.25 drv = 1'b0;
    #31.25 vid_clk = 1'b0;
  endtask
  task automatic stop_cond;
    #31.25 drv = 1'b0;
    #31.25 vid_clk = 1'b1;
    #31.25 drv = 1'b1;
    #31.25;
  endtask
  task automatic bit_out(input logic b);
    #31.25 drv = b;
    #31.25 vid_clk = 1'b1;
    #62.5 vid_clk = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    #31.25 drv = 1'b1;
    #31.25 vid_clk = 1'b1;
    #31.25 ack = ~vid_data;
    #31.25 vid_clk = 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/test_svss_startup.sv]
// Bench for the serial VID slave: pins, AHB-Lite registers and bus frames.
// Assumes the CPU master model on the bus wires; step period set to 2.
`timescale 1ns/1ps
`default_nettype none
`include "svss_defs.svh"
module test_svss_startup;
  logic        clk, rst_n, en, ctype, fix, pok, hsel, hwrite, rdy, hresp, d_out, oe_n, good, hint_n, c_on, a_on;
  logic [1:0]  htrans, ack;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, pre;
  logic [6:0]  c_ref, a_ref;
  logic [6:0]  boot_tab [4] = '{`SVSS_BOOT_VID_0, `SVSS_BOOT_VID_1, `SVSS_BOOT_VID_2, `SVSS_BOOT_VID_3};
  logic [6:0]  fix_tab [4] = '{`SVSS_FIX_VID_0, `SVSS_FIX_VID_1, `SVSS_FIX_VID_2, `SVSS_FIX_VID_3};
  wire logic   vclk, vdata;
  wire logic [31:0] rails = {14'h0, c_on, a_on, c_ref, a_ref, hint_n, good};
  int          n_errors = 0;
  int          samples_checked = 0;

  svss_cpu_master cpu (.dev_oe_n(oe_n), .dev_out(d_out), .vid_clk(vclk), .vid_data(vdata));
  svss_startup uut (.clk(clk), .rst_n(rst_n), .en(en), .cpu_type_select_pin(ctype), .fixed_voltage_strap(fix),
    .cpu_power_ok_in(pok), .serial_vid_clk(vclk), .serial_vid_data_in(vdata), .serial_vid_data_out(d_out),
    .serial_vid_data_oe_n(oe_n), .rails_good_out(good), .low_power_hint_n(hint_n), .core_vid_ref(c_ref),
    .core_rail_on(c_on), .aux_vid_ref(a_ref), .aux_rail_on(a_on), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata), .hreadyout(rdy), .hresp(hresp));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("Compared %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge clk); while (rdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = hrdata;
  endtask

  // Bounded wait for the rail state to settle, then compare
  task automatic expect_rails(input logic [31:0] exp);
    pre = exp;
    for (int i = 0; i < 3000 && rails !== exp; i++) @(posedge clk);
    check(rails, exp);
  endtask

  // Mid-frame, rails must still match the last expected state
  task automatic frame(input logic [7:0] a, input logic [7:0] d);
    cpu.start_cond();
    cpu.send_byte(a, ack[1]);
    cpu.send_byte(d, ack[0]);
    repeat (40) @(posedge clk);
    check(rails, pre);
    cpu.stop_cond();
    repeat (20) @(posedge clk);
  endtask

  initial begin
    #400000;
    n_errors++;
    $display("[FAIL] %0t: timeout", $time);
    print_verdict();
  end

  initial begin
    {rst_n, en, ctype, fix, pok, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ahb(1'b1, 32'h0000_0000, 32'h0000_0002);
    ahb(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
    ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
    check(rd, 32'h0000_0002);
    ahb(1'b0, 32'h0000_0040, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check(32'(hresp), 32'h0000_0000);
    $display("registers done");
    for (int c = 0; c < 4; c++) begin
      en <= 1'b0;
      repeat (8) @(posedge clk);
      cpu.set_lines(c[1], c[0]);
      en <= 1'b1;
      expect_rails({14'h0, 2'b11, boot_tab[c], boot_tab[c], 2'b11});
    end
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
    check(rd & 32'h0000_00FF, 32'h0000_0073);
    $display("boot done");
    frame(8'hC6, 8'h10);
    expect_rails({14'h0, 2'b11, 7'h3C, 7'h3C, 2'b11});
    ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
    check(rd & 32'h0001_0000, 32'h0001_0000);
    pok <= 1'b1;
    repeat (10) @(posedge clk);
    frame(8'hC6, 8'h28);
    check(32'(ack), 32'h0000_0003);
    expect_rails({14'h0, 2'b11, 7'h28, 7'h28, 2'b01});
    frame(8'hDA, 8'hFC);
    pre = {14'h0, 2'b10, 7'h28, 7'h28, 2'b11};
    check(rails, pre);
    frame(8'hC4, 8'h20);
    expect_rails({14'h0, 2'b10, 7'h20, 7'h28, 2'b01});
    frame(8'hC2, 8'hB0);
    expect_rails({14'h0, 2'b11, 7'h20, 7'h30, 2'b11});
    frame(8'hA6, 8'h10);
    check(32'(ack), 32'h0000_0000);
    cpu.start_cond();
    cpu.send_byte(8'hC6, ack[1]);
    cpu.bit_out(1'b0);
    cpu.bit_out(1'b1);
    cpu.stop_cond();
    repeat (40) @(posedge clk);
    check(rails, {14'h0, 2'b11, 7'h20, 7'h30, 2'b11});
    $display("commands done");
    pok <= 1'b0;
    repeat (8) @(posedge clk);
    check(32'(good), 32'h0000_0000);
    expect_rails({14'h0, 2'b11, 7'h3C, 7'h3C, 2'b11});
    $display("power-ok drop done");
    en <= 1'b0;
    fix <= 1'b1;
    // Power-ok high must make no difference in fixed mode
    pok <= 1'b1;
    repeat (8) @(posedge clk);
    en <= 1'b1;
    for (int c = 3; c >= 0; c--) begin
      cpu.set_lines(c[1], c[0]);
      expect_rails({14'h0, 2'b11, fix_tab[c], fix_tab[c], 2'b11});
    end
    $display("fixed mode done");
    en <= 1'b0;
    fix <= 1'b0;
    ctype <= 1'b1;
    repeat (8) @(posedge clk);
    en <= 1'b1;
    repeat (300) @(posedge clk);
    check(rails & 32'h0003_0001, 32'h0000_0000);
    $display("parallel mode done");
    print_verdict();
  end
endmodule
`default_nettype wire
